// ### verilog/msc_pkg.sv
// shared constants and types for the microstep sequencer and chopper
package msc_pkg;

	typedef enum logic [1:0] {TRI_LO = 2'h0, TRI_Z = 2'h1, TRI_HI = 2'h2} msc_tri_t;
	typedef enum logic [2:0] {
		FR_SLOW = 3'h0, FR_FAST = 3'h1, FR_8TH = 3'h2,
		FR_4TH = 3'h3, FR_HALF = 3'h4, FR_BLANK = 3'h5
	} msc_frac_t;
	typedef enum logic [2:0] {
		BR_IDLE = 3'h0, BR_DRIVE = 3'h1, BR_FAST = 3'h2,
		BR_COAST = 3'h3, BR_SLOW = 3'h4
	} msc_br_t;

	localparam int CLK_PERIOD_NS = 100;
	localparam int TOFF_Z_NS = 10000;
	localparam int TOFF_LO_NS = 20000;
	localparam int TOFF_HI_NS = 30000;
	localparam int BLANK_NS = 2000;
	localparam logic [9:0] TOFF_Z_CYC = 10'(TOFF_Z_NS / CLK_PERIOD_NS);
	localparam logic [9:0] TOFF_LO_CYC = 10'(TOFF_LO_NS / CLK_PERIOD_NS);
	localparam logic [9:0] TOFF_HI_CYC = 10'(TOFF_HI_NS / CLK_PERIOD_NS);
	localparam logic [9:0] BLANK_CYC = 10'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [6:0] HOME_POS = 7'h10;
	localparam logic [6:0] STEP_SIZE [0:8] = '{7'h20, 7'h10, 7'h08, 7'h04, 7'h04,
		7'h02, 7'h02, 7'h01, 7'h01};
	localparam logic [8:0] BOTH_EDGE = 9'h150;
	localparam logic [7:0] SINE_TAB [0:32] = '{8'h00, 8'h0D, 8'h19, 8'h25, 8'h32,
		8'h3E, 8'h4A, 8'h56, 8'h62, 8'h6D, 8'h78, 8'h83, 8'h8E, 8'h98, 8'hA2,
		8'hAB, 8'hB4, 8'hBD, 8'hC5, 8'hCD, 8'hD4, 8'hDB, 8'hE1, 8'hE7, 8'hEC,
		8'hF0, 8'hF4, 8'hF7, 8'hFA, 8'hFC, 8'hFE, 8'hFF, 8'hFF};
	localparam msc_frac_t DEC_INC [0:8] = '{FR_SLOW, FR_SLOW, FR_SLOW, FR_BLANK,
		FR_HALF, FR_4TH, FR_SLOW, FR_SLOW, FR_SLOW};
	localparam msc_frac_t DEC_DEC [0:8] = '{FR_SLOW, FR_4TH, FR_BLANK, FR_BLANK,
		FR_HALF, FR_4TH, FR_HALF, FR_8TH, FR_FAST};

	// gate bits are {hs1, ls1, hs2, ls2}
	localparam logic [3:0] GATE_OFF = 4'h0;
	localparam logic [3:0] GATE_POS = 4'h9;
	localparam logic [3:0] GATE_NEG = 4'h6;
	localparam logic [3:0] GATE_SLOW = 4'h5;

	function automatic logic [3:0] tri_idx(input msc_tri_t hi, input msc_tri_t lo);
		return 4'({2'h0, hi} * 4'h3 + {2'h0, lo});
	endfunction

	function automatic logic [9:0] frac_cyc(input msc_frac_t f, input logic [9:0] off);
		unique case (f)
			FR_SLOW: return 10'h000;
			FR_FAST: return off;
			FR_8TH: return off >> 3;
			FR_4TH: return off >> 2;
			FR_HALF: return off >> 1;
			default: return BLANK_CYC;
		endcase
	endfunction

endpackage

// ### verilog/msc_bridge.sv
// fixed off-time chopper state machine for one bridge
`timescale 1ns/10ps
module msc_bridge import msc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic trip_in,
	input wire logic zero_in,
	input wire logic adaptive_in,
	input msc_frac_t frac_in,
	input wire logic [9:0] off_cyc_in,
	output msc_br_t state_out
);
	msc_br_t next_state;
	logic [9:0] cnt;
	logic [9:0] next_cnt;
	logic [9:0] fast_len;
	logic [9:0] next_fast_len;
	logic [1:0] ovs;
	logic [1:0] next_ovs;
	logic off_end;
	logic blank_done;

	always_comb begin
		next_state = state_out;
		next_fast_len = fast_len;
		next_ovs = ovs;
		next_cnt = (cnt == 10'h3FF) ? cnt : cnt + 10'h001;
		off_end = (cnt >= off_cyc_in - 10'h001);
		blank_done = (cnt >= BLANK_CYC - 10'h001);
		if (!enable_in) begin
			next_state = BR_IDLE;
			next_cnt = 10'h000;
		end else begin
			unique case (state_out)
				BR_IDLE: begin
					next_state = BR_DRIVE;
					next_cnt = 10'h000;
				end
				BR_DRIVE: begin
					// comparator ignored until the window has run, see RULE21
					if (blank_done && trip_in) begin // see RULE8
						next_cnt = 10'h000;
						if (!adaptive_in) begin
							next_fast_len = frac_cyc(frac_in, off_cyc_in); // see RULE15
						end else if (cnt == BLANK_CYC - 10'h001) begin
							next_ovs = (ovs == 2'h3) ? ovs : ovs + 2'h1;
							// see RULE19
							next_fast_len = (ovs == 2'h0) ? BLANK_CYC :
								(ovs == 2'h1) ? 10'(BLANK_CYC << 1) : off_cyc_in >> 2;
						end else begin
							// late trip: slow only, see RULE18 RULE20
							next_ovs = 2'h0;
							next_fast_len = 10'h000;
						end
						next_state = (next_fast_len == 10'h000) ? BR_SLOW : BR_FAST;
					end
				end
				BR_FAST, BR_COAST: begin
					if (off_end) begin
						next_state = BR_DRIVE;
						next_cnt = 10'h000;
					end else if (cnt >= fast_len - 10'h001) begin
						next_state = BR_SLOW; // see RULE14
					end else if (state_out == BR_FAST && zero_in) begin
						next_state = BR_COAST; // see RULE12
					end
				end
				BR_SLOW: begin
					if (off_end) begin
						next_state = BR_DRIVE; // see RULE8
						next_cnt = 10'h000;
					end
				end
				default: begin
					next_state = BR_IDLE;
					next_cnt = 10'h000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_out <= BR_IDLE;
			cnt <= 10'h000;
			fast_len <= 10'h000;
			ovs <= 2'h0;
		end else begin
			state_out <= next_state;
			cnt <= next_cnt;
			fast_len <= next_fast_len;
			ovs <= next_ovs;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	blank_hold_a: assert property (state_out == BR_DRIVE && enable_in // see RULE21
		&& cnt < BLANK_CYC - 10'h001 |=> state_out == BR_DRIVE)
		else $error("drive left before blank window");
	off_end_a: assert property (state_out == BR_SLOW && enable_in && off_end // see RULE8
		|=> state_out == BR_DRIVE && cnt == 10'h000)
		else $error("off period did not end in drive");
	coast_a: assert property (state_out == BR_FAST && enable_in && zero_in // see RULE12
		&& !off_end && cnt < fast_len - 10'h001 |=> state_out == BR_COAST)
		else $error("fast decay did not stop at zero");
	mixed_slow_a: assert property (state_out == BR_FAST && enable_in && !off_end // see RULE14
		&& cnt >= fast_len - 10'h001 |=> state_out == BR_SLOW)
		else $error("mixed decay did not turn slow");
	escalate_a: assert property (state_out == BR_DRIVE && enable_in && adaptive_in // see RULE19
		&& trip_in && cnt == BLANK_CYC - 10'h001 && ovs == 2'h1
		|=> fast_len == 10'(BLANK_CYC << 1) && state_out == BR_FAST)
		else $error("second overshoot not two windows");
	late_slow_a: assert property (state_out == BR_DRIVE && enable_in && adaptive_in // see RULE18
		&& trip_in && cnt > BLANK_CYC - 10'h001 |=> state_out == BR_SLOW && ovs == 2'h0)
		else $error("late trip not slow");
	escalate_c: cover property (ovs == 2'h3 && state_out == BR_FAST);
	coast_c: cover property (state_out == BR_COAST);
endmodule

// ### verilog/msc_top.sv
// step/direction sequencer with two chopper bridges
// What this block and its step controller do
// RULE1: controller holds step high and low 1.9us
// RULE2: each active edge moves one step
// RULE3: full, half, quarter advance on rising only
// RULE4: fine modes: rising-only or both-edge codes
// RULE5: inhibit turns bridges off, sequencer keeps tracking
// RULE6: resolution change jumps to next valid position
// RULE7: home at 45 degrees after reset, lockout, sleep
// RULE8: drive to threshold, fixed off, drive again
// RULE9: off time Z 10us, low 20us, high 30us
// RULE10: threshold is reference times torque times sine
// RULE11: nine torque scales, both high means off
// RULE12: fast decay reverses, stops near zero current
// RULE13: slow decay turns both low sides on
// RULE14: mixed decay fast first, then slow
// RULE15: falling current decay chosen by decay pins
// RULE16: rising current mixed on three codes only
// RULE17: auto recirculation sampled only at wake
// RULE18: long drive gives slow decay next
// RULE19: repeated overshoot escalates fast decay length
// RULE20: short drive gives slow until above reference
// RULE21: drive lasts blank window, comparator ignored
// RULE22: standby low: regulator, bridges, sequencer off
// RULE23: tri-level pins decode to three values
// RULE24: position wraps over one electrical cycle
`timescale 1ns/10ps
module msc_top import msc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic step_in,
	input wire logic rotation_sense_in,
	input wire logic output_inhibit_in,
	input wire logic standby_request_in,
	input wire logic uvlo_in,
	input wire logic auto_recirc_en_in,
	input wire logic step_res_sel0_lvl_in,
	input wire logic step_res_sel0_hiz_in,
	input wire logic step_res_sel1_lvl_in,
	input wire logic step_res_sel1_hiz_in,
	input wire logic off_time_sel_lvl_in,
	input wire logic off_time_sel_hiz_in,
	input wire logic torque_sel0_lvl_in,
	input wire logic torque_sel0_hiz_in,
	input wire logic torque_sel1_lvl_in,
	input wire logic torque_sel1_hiz_in,
	input wire logic decay_sel0_lvl_in,
	input wire logic decay_sel0_hiz_in,
	input wire logic decay_sel1_lvl_in,
	input wire logic decay_sel1_hiz_in,
	input wire logic [7:0] chop_reference_in,
	input wire logic a_trip_in,
	input wire logic b_trip_in,
	input wire logic a_zero_in,
	input wire logic b_zero_in,
	output logic [3:0] a_gate_out,
	output logic [3:0] b_gate_out,
	output logic [7:0] a_thresh_out,
	output logic [7:0] b_thresh_out,
	output logic regulator_en_out,
	output logic [6:0] position_out
);
	logic awake;
	logic awake_q;
	logic step_prev;
	logic step_rise;
	logic step_fall;
	logic adv;
	logic adaptive;
	logic next_adaptive;
	logic rise_a;
	logic rise_b;
	logic next_rise_a;
	logic next_rise_b;
	logic en;
	logic [3:0] res_idx;
	logic [3:0] tq_idx;
	logic [3:0] dec_idx;
	logic [3:0] scale;
	logic [9:0] off_cyc;
	logic [6:0] next_pos;
	logic [3:0] next_a_gate;
	logic [3:0] next_b_gate;
	logic [7:0] next_a_thr;
	logic [7:0] next_b_thr;
	msc_tri_t off_tri;
	msc_frac_t frac_a;
	msc_frac_t frac_b;
	msc_br_t a_state;
	msc_br_t b_state;

	// the analog front end flags a floating pin; that wins over the level
	function automatic msc_tri_t tri_dec(input logic lvl, input logic hiz);
		if (hiz) begin
			return TRI_Z;
		end
		return lvl ? TRI_HI : TRI_LO;
	endfunction

	// step measured from home so full steps stay on 45 degree points
	function automatic logic [6:0] nxt_pos(input logic [6:0] p, input logic [6:0] sz,
		input logic fwd);
		logic [6:0] o;
		logic [6:0] al;
		o = p - HOME_POS;
		al = o & ~(sz - 7'h01);
		if (fwd) begin
			o = al + sz;
		end else begin
			o = (o == al) ? al - sz : al;
		end
		return o + HOME_POS;
	endfunction

	// winding a follows sine, b cosine, over 128 positions
	function automatic logic [7:0] mag(input logic [6:0] p, input logic cosn);
		logic [5:0] q;
		q = {1'b0, p[4:0]};
		if (p[5] ^ cosn) begin
			q = 6'h20 - q;
		end
		return SINE_TAB[q];
	endfunction

	function automatic logic [7:0] thr_of(input logic [7:0] r, input logic [3:0] s,
		input logic [7:0] m);
		logic [11:0] tq;
		logic [15:0] full;
		tq = r * s;
		full = tq[10:3] * m;
		return full[15:8];
	endfunction

	function automatic logic [3:0] gate_of(input msc_br_t st, input logic pos_sign);
		unique case (st)
			BR_DRIVE: return pos_sign ? GATE_POS : GATE_NEG;
			BR_FAST: return pos_sign ? GATE_NEG : GATE_POS; // see RULE12
			BR_SLOW: return GATE_SLOW; // see RULE13
			default: return GATE_OFF;
		endcase
	endfunction

	always_comb begin
		awake = standby_request_in && !uvlo_in;
		step_rise = step_in && !step_prev;
		step_fall = !step_in && step_prev;
		// see RULE23
		res_idx = tri_idx(tri_dec(step_res_sel1_lvl_in, step_res_sel1_hiz_in),
			tri_dec(step_res_sel0_lvl_in, step_res_sel0_hiz_in));
		tq_idx = tri_idx(tri_dec(torque_sel1_lvl_in, torque_sel1_hiz_in),
			tri_dec(torque_sel0_lvl_in, torque_sel0_hiz_in));
		dec_idx = tri_idx(tri_dec(decay_sel1_lvl_in, decay_sel1_hiz_in),
			tri_dec(decay_sel0_lvl_in, decay_sel0_hiz_in));
		off_tri = tri_dec(off_time_sel_lvl_in, off_time_sel_hiz_in);
		// see RULE3 RULE4
		adv = step_rise || (step_fall && BOTH_EDGE[res_idx]);
		scale = 4'h8 - tq_idx; // see RULE11
		en = awake && !output_inhibit_in && scale != 4'h0; // see RULE5 RULE22
		unique case (off_tri)
			TRI_Z: off_cyc = TOFF_Z_CYC; // see RULE9
			TRI_LO: off_cyc = TOFF_LO_CYC;
			default: off_cyc = TOFF_HI_CYC;
		endcase
	end

	always_comb begin
		next_pos = position_out;
		next_rise_a = rise_a;
		next_rise_b = rise_b;
		next_adaptive = adaptive;
		if (!awake) begin
			next_pos = HOME_POS; // see RULE7 RULE22
		end else if (adv) begin
			// modulo arithmetic wraps both ways, see RULE2 RULE6 RULE24
			next_pos = nxt_pos(position_out, STEP_SIZE[res_idx], rotation_sense_in);
			next_rise_a = mag(next_pos, 1'b0) > mag(position_out, 1'b0);
			next_rise_b = mag(next_pos, 1'b1) > mag(position_out, 1'b1);
		end
		if (awake && !awake_q) begin
			next_adaptive = auto_recirc_en_in; // see RULE17
		end
		// see RULE15 RULE16
		frac_a = rise_a ? DEC_INC[dec_idx] : DEC_DEC[dec_idx];
		frac_b = rise_b ? DEC_INC[dec_idx] : DEC_DEC[dec_idx];
		next_a_thr = thr_of(chop_reference_in, scale, mag(position_out, 1'b0)); // see RULE10
		next_b_thr = thr_of(chop_reference_in, scale, mag(position_out, 1'b1));
		// gates follow en directly so an inhibit acts in one cycle
		next_a_gate = en ? gate_of(a_state, !position_out[6]) : GATE_OFF; // see RULE5
		next_b_gate = en ? gate_of(b_state, !(position_out[6] ^ position_out[5])) : GATE_OFF;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			position_out <= HOME_POS; // see RULE7
			step_prev <= 1'b0;
			awake_q <= 1'b0;
			adaptive <= 1'b0;
			rise_a <= 1'b0;
			rise_b <= 1'b0;
			a_gate_out <= GATE_OFF;
			b_gate_out <= GATE_OFF;
			a_thresh_out <= 8'h00;
			b_thresh_out <= 8'h00;
			regulator_en_out <= 1'b0;
		end else begin
			position_out <= next_pos;
			step_prev <= step_in;
			awake_q <= awake;
			adaptive <= next_adaptive;
			rise_a <= next_rise_a;
			rise_b <= next_rise_b;
			a_gate_out <= next_a_gate;
			b_gate_out <= next_b_gate;
			a_thresh_out <= next_a_thr;
			b_thresh_out <= next_b_thr;
			regulator_en_out <= awake; // see RULE22
		end
	end

	msc_bridge u_bridge_a (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.enable_in(en),
		.trip_in(a_trip_in),
		.zero_in(a_zero_in),
		.adaptive_in(adaptive),
		.frac_in(frac_a),
		.off_cyc_in(off_cyc),
		.state_out(a_state)
	);

	msc_bridge u_bridge_b (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.enable_in(en),
		.trip_in(b_trip_in),
		.zero_in(b_zero_in),
		.adaptive_in(adaptive),
		.frac_in(frac_b),
		.off_cyc_in(off_cyc),
		.state_out(b_state)
	);

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	home_on_sleep_a: assert property (!standby_request_in // see RULE7
		|=> position_out == HOME_POS)
		else $error("sequencer not home in sleep");
	rise_only_a: assert property (awake && step_fall && res_idx < 4'h3 // see RULE3
		|=> position_out == $past(position_out))
		else $error("coarse mode moved on falling edge");
	both_edge_a: assert property (awake && step_fall && res_idx == 4'h8 // see RULE4
		&& rotation_sense_in |=> position_out == $past(position_out) + 7'h01)
		else $error("both-edge mode missed falling edge");
	realign_a: assert property (awake && step_rise && res_idx == 4'h0 // see RULE6
		&& rotation_sense_in && position_out == 7'h11 |=> position_out == 7'h30)
		else $error("mode change did not realign");
	wrap_a: assert property (awake && step_rise && res_idx == 4'h7 // see RULE24
		&& !rotation_sense_in && position_out == 7'h00 |=> position_out == 7'h7F)
		else $error("position did not wrap");
	inhibit_off_a: assert property (output_inhibit_in // see RULE5
		|=> a_gate_out == GATE_OFF && b_gate_out == GATE_OFF)
		else $error("bridge on while inhibited");
	sleep_off_a: assert property (!standby_request_in // see RULE22
		|=> !regulator_en_out && a_gate_out == GATE_OFF && b_gate_out == GATE_OFF)
		else $error("regulator or bridge on in sleep");
	zero_torque_a: assert property (tq_idx == 4'h8 // see RULE11
		|=> a_thresh_out == 8'h00 && b_gate_out == GATE_OFF)
		else $error("zero torque still drives");
	adaptive_hold_a: assert property (awake && awake_q // see RULE17
		|=> adaptive == $past(adaptive))
		else $error("auto recirculation changed while awake");
	slow_gate_a: assert property (en && a_state == BR_SLOW // see RULE13
		|=> a_gate_out == GATE_SLOW)
		else $error("slow decay gates wrong");
	fast_gate_a: assert property (en && b_state == BR_FAST // see RULE12
		|=> b_gate_out == GATE_POS || b_gate_out == GATE_NEG)
		else $error("fast decay gates wrong");
	full_align_a: assert property (awake && step_rise && res_idx == 4'h0 // see RULE3
		|=> ((position_out - HOME_POS) & 7'h1F) == 7'h00)
		else $error("full step off a 45 degree point");
	half_align_a: assert property (awake && step_rise && res_idx == 4'h1 // see RULE3
		|=> ((position_out - HOME_POS) & 7'h0F) == 7'h00)
		else $error("half step misaligned");
	quarter_align_a: assert property (awake && step_rise && res_idx == 4'h2 // see RULE3
		|=> ((position_out - HOME_POS) & 7'h07) == 7'h00)
		else $error("quarter step misaligned");
	eighth_align_a: assert property (awake && adv && (res_idx == 4'h3 || res_idx == 4'h4) // see RULE4
		|=> ((position_out - HOME_POS) & 7'h03) == 7'h00)
		else $error("eighth step misaligned");
	fine_align_a: assert property (awake && adv && (res_idx == 4'h5 || res_idx == 4'h6) // see RULE4
		|=> ((position_out - HOME_POS) & 7'h01) == 7'h00)
		else $error("sixteenth step misaligned");
	fine_rise_only_a: assert property (awake && step_fall && (res_idx == 4'h3 // see RULE4
		|| res_idx == 4'h5 || res_idx == 4'h7) |=> position_out == $past(position_out))
		else $error("rise-only fine mode moved on falling edge");
	eighth_both_a: assert property (awake && step_fall && res_idx == 4'h4 // see RULE4
		&& rotation_sense_in && ((position_out - HOME_POS) & 7'h03) == 7'h00
		|=> position_out == $past(position_out) + 7'h04)
		else $error("eighth both-edge step wrong");
	fwd_full_a: assert property (awake && step_rise && res_idx == 4'h0 && rotation_sense_in // see RULE2
		&& ((position_out - HOME_POS) & 7'h1F) == 7'h00 |=> position_out == $past(position_out) + 7'h20)
		else $error("forward full step wrong");
	back_full_a: assert property (awake && step_rise && res_idx == 4'h0 && !rotation_sense_in // see RULE2
		&& ((position_out - HOME_POS) & 7'h1F) == 7'h00 |=> position_out == $past(position_out) - 7'h20)
		else $error("backward full step wrong");
	realign_back_a: assert property (awake && step_rise && res_idx == 4'h0 // see RULE6
		&& !rotation_sense_in && position_out == 7'h1E |=> position_out == 7'h10)
		else $error("backward mode change did not realign");
	wrap_full_a: assert property (awake && step_rise && res_idx == 4'h0 // see RULE24
		&& !rotation_sense_in && position_out == 7'h10 |=> position_out == 7'h70)
		else $error("full step did not wrap backward");
	no_edge_hold_a: assert property (awake && !step_rise && !step_fall // see RULE2
		|=> position_out == $past(position_out))
		else $error("position moved without a step edge");
	drive_pos_a: assert property (en && a_state == BR_DRIVE && !position_out[6] // see RULE8
		|=> a_gate_out == GATE_POS)
		else $error("positive drive gates wrong");
	drive_neg_a: assert property (en && a_state == BR_DRIVE && position_out[6] // see RULE8
		|=> a_gate_out == GATE_NEG)
		else $error("negative drive gates wrong");
	fast_rev_a: assert property (en && a_state == BR_FAST && !position_out[6] // see RULE12
		|=> a_gate_out == GATE_NEG)
		else $error("fast decay did not reverse the bridge");
	zero_thresh_a: assert property (tq_idx == 4'h8 // see RULE11
		|=> b_thresh_out == 8'h00 && a_gate_out == GATE_OFF)
		else $error("zero torque leaves a threshold");
	full_scale_a: assert property (tq_idx == 4'h0 && chop_reference_in == 8'hFF // see RULE10
		&& position_out == HOME_POS |=> a_thresh_out == 8'hB3 && b_thresh_out == 8'hB3)
		else $error("full scale home threshold wrong");
	equal_home_a: assert property (position_out == HOME_POS // see RULE10
		|=> a_thresh_out == b_thresh_out)
		else $error("windings differ at home");
	inhibit_track_a: assert property (awake && output_inhibit_in && step_rise // see RULE5
		&& res_idx == 4'h0 && rotation_sense_in |=> position_out != $past(position_out))
		else $error("sequencer stopped while inhibited");
	adaptive_sample_a: assert property (awake && !awake_q // see RULE17
		|=> adaptive == $past(auto_recirc_en_in))
		else $error("auto recirculation not sampled at wake");
	regulator_on_a: assert property (awake // see RULE22
		|=> regulator_en_out)
		else $error("regulator off while awake");

	full_cycle_c: cover property (awake && adv && position_out == 7'h70 ##1 position_out == 7'h10);
	fall_step_c: cover property (awake && step_fall && adv);
	adaptive_c: cover property (adaptive && a_state == BR_FAST);
	mixed_c: cover property (a_state == BR_FAST ##[1:300] a_state == BR_SLOW);
endmodule

// ### testbench/msc_ctrl_model.sv
// motion controller model driving step and direction pins
`timescale 1ns/10ps
module msc_ctrl_model #(
	parameter int HOLD_CYC = 19
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic edge_req_in,
	input wire logic dir_req_in,
	output logic step_out,
	output logic dir_out
);
	int hold;
	// each step level held at least HOLD_CYC clocks
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			step_out <= 1'b0;
			dir_out <= 1'b1;
			hold <= 0;
		end else if (hold < HOLD_CYC) begin
			hold <= hold + 1;
		end else if (edge_req_in && dir_req_in !== dir_out) begin
			// direction gets setup time before the next step edge
			dir_out <= dir_req_in;
			hold <= HOLD_CYC - 3;
		end else if (edge_req_in) begin
			step_out <= ~step_out;
			hold <= 0;
		end
	end
endmodule

// ### testbench/microstep_sequencer_chopper_test.sv
// self-checking bench for the sequencer and chopper top
`timescale 1ns/10ps
module microstep_sequencer_chopper_test;
	import msc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic standby = 1'b1;
	logic inhibit = 1'b0;
	logic edge_req = 1'b0;
	logic dir_req = 1'b1;
	logic a_trip = 1'b0;
	logic [7:0] ref_lvl = 8'hFF;
	msc_tri_t res1 = TRI_LO;
	msc_tri_t res0 = TRI_LO;
	msc_tri_t offt = TRI_LO;
	msc_tri_t tq1 = TRI_LO;
	msc_tri_t tq0 = TRI_LO;
	msc_tri_t dec1 = TRI_LO;
	msc_tri_t dec0 = TRI_LO;
	logic step;
	logic dir;
	logic [3:0] a_gate;
	logic [3:0] b_gate;
	logic [7:0] a_thr;
	logic [7:0] b_thr;
	logic reg_en;
	logic [6:0] pos;
	logic [6:0] epos = 7'h10;
	int fails = 0;
	int cmp_count = 0;

	always #50 clk = ~clk;

	msc_ctrl_model msc_ctrl_model_inst (.clk_in(clk), .rst_in(rst), .edge_req_in(edge_req),
		.dir_req_in(dir_req), .step_out(step), .dir_out(dir));

	// decay pins start low: slow recirculation for rising and falling current
	msc_top msc_top_inst (.clk_in(clk), .rst_in(rst), .step_in(step), .rotation_sense_in(dir),
		.output_inhibit_in(inhibit), .standby_request_in(standby), .uvlo_in(1'b0),
		.auto_recirc_en_in(1'b0),
		.step_res_sel0_lvl_in(res0 == TRI_HI), .step_res_sel0_hiz_in(res0 == TRI_Z),
		.step_res_sel1_lvl_in(res1 == TRI_HI), .step_res_sel1_hiz_in(res1 == TRI_Z),
		.off_time_sel_lvl_in(offt == TRI_HI), .off_time_sel_hiz_in(offt == TRI_Z),
		.torque_sel0_lvl_in(tq0 == TRI_HI), .torque_sel0_hiz_in(tq0 == TRI_Z),
		.torque_sel1_lvl_in(tq1 == TRI_HI), .torque_sel1_hiz_in(tq1 == TRI_Z),
		.decay_sel0_lvl_in(dec0 == TRI_HI), .decay_sel0_hiz_in(dec0 == TRI_Z),
		.decay_sel1_lvl_in(dec1 == TRI_HI), .decay_sel1_hiz_in(dec1 == TRI_Z),
		.chop_reference_in(ref_lvl), .a_trip_in(a_trip), .b_trip_in(1'b0),
		.a_zero_in(1'b0), .b_zero_in(1'b0), .a_gate_out(a_gate), .b_gate_out(b_gate),
		.a_thresh_out(a_thr), .b_thresh_out(b_thr), .regulator_en_out(reg_en),
		.position_out(pos));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	function automatic logic [6:0] nxt(logic [6:0] p, int idx, logic fwd, logic rise);
		logic [6:0] s;
		logic [6:0] o;
		logic [6:0] a;
		s = STEP_SIZE[idx];
		o = p - 7'h10;
		a = o & ~(s - 7'h01);
		if (!rise && !BOTH_EDGE[idx]) begin
			return p;
		end
		if (fwd) begin
			a = a + s;
		end else if (o == a) begin
			a = a - s;
		end
		return a + 7'h10;
	endfunction

	function automatic logic drv(logic [3:0] g);
		return g === GATE_POS || g === GATE_NEG;
	endfunction

	// one step edge through the controller model, then position compare
	task automatic step_edge(input logic fwd);
		logic old;
		int n;
		old = step;
		dir_req = fwd;
		edge_req = 1'b1;
		n = 0;
		while (step === old && n < 200) begin
			@(negedge clk);
			n++;
		end
		edge_req = 1'b0;
		if (standby) begin
			epos = nxt(epos, int'(res1) * 3 + int'(res0), fwd, step === 1'b1);
		end
		repeat (2) @(negedge clk);
		check("position", pos, epos);
	endtask

	// fresh drive phase, trip, measure blanking, fast part and off period
	task automatic chop(input msc_tri_t t, input int fast, input logic [9:0] exp);
		int n;
		int d;
		int f;
		offt = t;
		inhibit = 1'b1;
		repeat (3) @(negedge clk);
		inhibit = 1'b0;
		n = 0;
		while (!drv(a_gate) && n < 50) begin
			@(negedge clk);
			n++;
		end
		a_trip = 1'b1;
		d = 0;
		f = 0;
		n = 0;
		// home drives winding a positive, so fast decay shows the reverse pair
		while (a_gate !== GATE_SLOW && n < 400) begin
			d += int'(a_gate === GATE_POS);
			f += int'(a_gate === GATE_NEG);
			@(negedge clk);
			n++;
		end
		check("drive_len", 32'(d >= int'(BLANK_CYC)), 1);
		check("fast_len", f, fast);
		a_trip = 1'b0;
		n = 0;
		while (a_gate === GATE_SLOW && n < 400) begin
			@(negedge clk);
			n++;
		end
		check("off_len", n + f, 32'(exp));
		check("redrive", drv(a_gate), 1);
	endtask

	initial begin
		#3_000_000;
		fails++;
		summarize();
	end

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		check("home", pos, 7'h10);
		check("regulator", reg_en, 1);
		// all nine torque codes; 45 degree home gives equal sine on both windings
		for (int i = 0; i < 9; i++) begin
			tq1 = msc_tri_t'(i / 3);
			tq0 = msc_tri_t'(i % 3);
			repeat (4) @(negedge clk);
			check("a_thresh", a_thr, 32'((((255 * (8 - i)) >> 3) * SINE_TAB[16]) >> 8));
			check("b_thresh", b_thr, 32'((((255 * (8 - i)) >> 3) * SINE_TAB[16]) >> 8));
		end
		check("tq_off_gate", a_gate, GATE_OFF);
		tq1 = TRI_LO;
		tq0 = TRI_LO;
		chop(TRI_LO, 0, TOFF_LO_CYC);
		// falling current at home: 0/1 gives one window fast, 0/Z a quarter
		dec0 = TRI_HI;
		chop(TRI_Z, int'(BLANK_CYC), TOFF_Z_CYC);
		dec0 = TRI_Z;
		chop(TRI_HI, int'(TOFF_HI_CYC) / 4, TOFF_HI_CYC);
		// every resolution code in turn, mode changes in motion
		for (int i = 0; i < 9; i++) begin
			res1 = msc_tri_t'(i / 3);
			res0 = msc_tri_t'(i % 3);
			for (int k = 0; k < 4; k++) begin
				step_edge(k != 2);
			end
		end
		res1 = TRI_LO;
		res0 = TRI_LO;
		// full steps backward across the wrap point
		for (int k = 0; k < 10; k++) begin
			step_edge(1'b0);
		end
		inhibit = 1'b1;
		repeat (2) @(negedge clk);
		check("inh_gate_a", a_gate, GATE_OFF);
		check("inh_gate_b", b_gate, GATE_OFF);
		step_edge(1'b1);
		step_edge(1'b1);
		inhibit = 1'b0;
		standby = 1'b0;
		epos = 7'h10;
		repeat (3) @(negedge clk);
		check("sleep_reg", reg_en, 0);
		check("sleep_gate", a_gate, GATE_OFF);
		step_edge(1'b1);
		standby = 1'b1;
		repeat (3) @(negedge clk);
		check("wake_home", pos, 7'h10);
		summarize();
	end
endmodule
